// *** hw/spio_pkg.sv ***
// Package of constants and carrier types for the shared pin I/O port
package spio_pkg;

  // ----------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------
  localparam int PIN_W = 16;                       // Pins in one port
  localparam int ADDR_W = 4;                       // Avalon byte address width
  localparam int DATA_W = 32;                      // Avalon data width
  localparam int BE_W = 4;                         // Avalon byte enables
  localparam logic [PIN_W-1:0] PIN_IMPL_MASK = 16'h3FFF;   // Pins that exist
  localparam logic [PIN_W-1:0] PERIPH_OUT_MASK = 16'h00FF; // Pins with output peripherals

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_OPEN_DRAIN_SELECT = 4'hC;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PIN_W-1:0] RST_PIN_DIRECTION = PIN_IMPL_MASK; // Every implemented pin an input
  localparam logic [PIN_W-1:0] RST_OUTPUT_LATCH = 16'h0000;
  localparam logic [PIN_W-1:0] RST_OPEN_DRAIN_SELECT = 16'h0000;
  localparam logic [DATA_W-1:0] RST_READDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Output path of a sharing peripheral, one bit per pin
  typedef struct packed {
    logic [PIN_W-1:0] enable;  // Peripheral switched on
    logic [PIN_W-1:0] drive;   // Peripheral actively driving the pin
    logic [PIN_W-1:0] data;    // Peripheral output value
  } spio_periph_t;

  // Pad drive toward the pins
  typedef struct packed {
    logic [PIN_W-1:0] out;     // Output value
    logic [PIN_W-1:0] oe;      // Output enable, high while driving
  } spio_pad_t;

  // Bus state
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } spio_bus_state_t;

endpackage : spio_pkg

// *** hw/spio_pin_cell.sv ***
// One pin of the shared pin I/O port: output mux, open drain and input synchroniser
`timescale 1ns/1ps
module spio_pin_cell
  import spio_pkg::*;
#(
  parameter bit HAS_PERIPH_OUT = 1'b1            // Pin has an output-capable peripheral
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_impl,                       // Pin exists on this part
  input wire logic i_latch,                      // Output latch bit
  input wire logic i_dir,                        // Direction bit, 1 = input
  input wire logic i_od,                         // Open drain select bit
  input wire logic i_periph_en,
  input wire logic i_periph_drive,
  input wire logic i_periph_data,
  input wire logic i_pin_in,                     // Raw pad level, asynchronous
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_level,                          // Synchronised pin level
  output logic o_periph_in                       // Level seen by the peripheral
);

  // ----------------------------------------------------------------
  // Output multiplexers
  // ----------------------------------------------------------------
  logic owns;        // Peripheral holds the output path
  logic sel_data;    // Value chosen for the pad
  logic sel_drive;   // Drive request chosen for the pad
  logic port_drives; // Port itself is driving the pad
  logic next_oe;
  logic next_out;
  logic sync_meta;   // First synchroniser stage, read only by the second
  logic sync_level;

  // Input-only sharers never compete, so they cannot take the pin
  assign owns = HAS_PERIPH_OUT & i_periph_en & i_periph_drive;        // R9 R11 R13
  assign sel_data = owns ? i_periph_data : i_latch;                   // R8
  assign port_drives = i_impl & ~owns & ~i_dir;                       // R1
  assign sel_drive = i_impl & (owns | ~i_dir);                        // R8
  // Open drain only ever pulls low; a one releases the pad
  assign next_oe = sel_drive & (i_od ? ~sel_data : 1'b1);             // R14 R15
  assign next_out = i_od ? 1'b0 : sel_data;                           // R14 R15

  // Pad drive is registered so the pad never sees mux glitches
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_out <= next_out;
      o_pin_oe <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  // Two stages; the first goes nowhere but the second
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_meta <= 1'b0;
      sync_level <= 1'b0;
    end else begin
      sync_meta <= i_pin_in;                                          // R16
      sync_level <= sync_meta;                                        // R16
    end
  end

  assign o_level = i_impl & sync_level;                               // R7 R10
  // The port's own drive must not loop back into a sharing peripheral
  assign o_periph_in = port_drives ? 1'b0 : o_level;                  // R12

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_input_no_drive: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R1
    (i_dir && !owns) |=> !o_pin_oe)
    else $error("input pin is being driven");
  chk_periph_owns: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R9
    (owns && i_impl && !i_od) |=> (o_pin_oe && o_pin_out == $past(i_periph_data)))
    else $error("peripheral does not own its pin");
  chk_od_release: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R15
    (i_od && sel_data) |=> (!o_pin_oe && !o_pin_out))
    else $error("open drain pin not released");
  chk_loop_block: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R12
    (i_impl && !i_dir && !owns) |-> !o_periph_in)
    else $error("port output loops into peripheral");
  chk_sync_depth: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R16
    ##2 (i_impl && $stable(i_impl)) |-> (o_level == $past(i_pin_in, 2)))
    else $error("pin level not two stages late");

endmodule // spio_pin_cell

// *** hw/spio_port.sv ***
// Shared pin I/O port: Avalon-MM registers, per-pin muxes and synchronisers
//
// Summary of operation
// R1 - Direction one is input, zero drives latch
// R2 - Reset sets every implemented direction bit to input
// R3 - Latch read returns stored latch contents
// R4 - Latch write updates the stored latch
// R5 - Level read returns synchronised pin levels
// R6 - Level write updates the latch instead
// R7 - Missing pins read zero everywhere
// R8 - Muxes pick port or peripheral output
// R9 - Driving peripheral disables the port driver
// R10 - Pin level readable while peripheral owns
// R11 - Enabled idle peripheral leaves port control
// R12 - Port output never loops into peripherals
// R13 - Input-only sharing leaves pin port-controlled
// R14 - Open drain select chooses open drain
// R15 - Open drain pulls low, releases on one
// R16 - Pin levels pass two synchroniser stages
`timescale 1ns/1ps
module spio_port
  import spio_pkg::*;
(
  input wire logic i_clk_sys,                    // 100 MHz system clock
  input wire logic i_arst_n,                     // Asynchronous reset, active low
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [DATA_W-1:0] i_writedata,
  input wire logic [BE_W-1:0] i_byteenable,
  output logic [DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  // Sharing peripherals
  input wire spio_periph_t i_periph,
  output logic [PIN_W-1:0] o_periph_in,
  // Pads
  input wire logic [PIN_W-1:0] i_pin_in,
  output spio_pad_t o_pad
);

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_direction;               // 1 = input
  logic [PIN_W-1:0] output_latch;                // Stored output values
  logic [PIN_W-1:0] open_drain_select;           // 1 = open drain
  logic [PIN_W-1:0] pin_level;                   // Synchronised pad levels
  spio_bus_state_t bus_state;                    // Idle or answering
  spio_bus_state_t next_bus_state;
  logic req;                                     // Read or write presented
  logic accept;                                  // Edge at which the request completes
  logic wr_accept;                               // Write takes effect now
  logic [PIN_W-1:0] lane_mask;                   // Bits touched by byte enables
  logic [PIN_W-1:0] wdata;                       // Write data cut to port width
  logic [PIN_W-1:0] next_readdata;               // Value captured for a read

  assign req = i_read | i_write;
  assign accept = req & (bus_state == BUS_ANSWER);
  assign wr_accept = i_write & accept;
  assign wdata = i_writedata[PIN_W-1:0];
  assign lane_mask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Every access costs one wait cycle; that cycle registers the read
  // data so the answer never runs combinationally off the pads.
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // Handshake state
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Waitrequest is combinational, high only in the wait cycle
  assign o_waitrequest = req & (bus_state != BUS_ANSWER);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; upper half is always zero
  always_comb begin
    next_readdata = 16'h0000;
    unique case (i_address)
      OFS_PIN_DIRECTION: begin
        next_readdata = pin_direction & PIN_IMPL_MASK;               // R7
      end
      OFS_OUTPUT_LATCH: begin
        next_readdata = output_latch & PIN_IMPL_MASK;                // R3 R7
      end
      OFS_PIN_LEVEL: begin
        next_readdata = pin_level;                                   // R5 R10
      end
      OFS_OPEN_DRAIN_SELECT: begin
        next_readdata = open_drain_select & PIN_IMPL_MASK;
      end
      default: begin
        next_readdata = 16'h0000;
      end
    endcase
  end

  // Read data is captured in the wait cycle and held through the answer
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_readdata <= RST_READDATA;
    end else if (i_read && bus_state == BUS_IDLE) begin
      o_readdata <= {16'h0000, next_readdata};
    end
  end

  // ----------------------------------------------------------------
  // Direction register
  // ----------------------------------------------------------------
  // Reset makes every implemented pin an input
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_direction <= RST_PIN_DIRECTION;                            // R2
    end else if (wr_accept && i_address == OFS_PIN_DIRECTION) begin
      pin_direction <= ((pin_direction & ~lane_mask) | (wdata & lane_mask))
        & PIN_IMPL_MASK;                                             // R1 R7
    end
  end

  // ----------------------------------------------------------------
  // Output latch
  // ----------------------------------------------------------------
  // Writes to the level register land here too; pads are never
  // written directly, so a read-modify-write of the level can corrupt
  // latch bits of input pins, a known limitation for software.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      output_latch <= RST_OUTPUT_LATCH;
    end else if (wr_accept && (i_address == OFS_OUTPUT_LATCH
                               || i_address == OFS_PIN_LEVEL)) begin
      output_latch <= ((output_latch & ~lane_mask) | (wdata & lane_mask))
        & PIN_IMPL_MASK;                                             // R4 R6 R7
    end
  end

  // ----------------------------------------------------------------
  // Open drain select
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      open_drain_select <= RST_OPEN_DRAIN_SELECT;
    end else if (wr_accept && i_address == OFS_OPEN_DRAIN_SELECT) begin
      open_drain_select <= ((open_drain_select & ~lane_mask) | (wdata & lane_mask))
        & PIN_IMPL_MASK;                                             // R14
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // One cell per pin; cells for missing pins stay inert
  for (genvar g = 0; g < PIN_W; g++) begin : g_pin
    spio_pin_cell #(
      .HAS_PERIPH_OUT(PERIPH_OUT_MASK[g])                            // R13
    ) u_cell (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_impl(PIN_IMPL_MASK[g]),
      .i_latch(output_latch[g]),
      .i_dir(pin_direction[g]),
      .i_od(open_drain_select[g]),
      .i_periph_en(i_periph.enable[g]),
      .i_periph_drive(i_periph.drive[g]),
      .i_periph_data(i_periph.data[g]),
      .i_pin_in(i_pin_in[g]),
      .o_pin_out(o_pad.out[g]),
      .o_pin_oe(o_pad.oe[g]),
      .o_level(pin_level[g]),
      .o_periph_in(o_periph_in[g])
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Bus steps of one access
  sequence s_wait_cycle;
    req && o_waitrequest;
  endsequence

  sequence s_answer;
    req && !o_waitrequest;
  endsequence

  chk_bus_answer: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    s_wait_cycle |=> s_answer)
    else $error("access not answered after one wait cycle");
  chk_latch_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R4
    (wr_accept && i_address == OFS_OUTPUT_LATCH && i_byteenable == 4'hF)
    |=> (output_latch == ($past(wdata) & PIN_IMPL_MASK)))
    else $error("latch write lost");
  chk_level_write: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R6
    (wr_accept && i_address == OFS_PIN_LEVEL && i_byteenable == 4'hF)
    |=> (output_latch == ($past(wdata) & PIN_IMPL_MASK)))
    else $error("level write did not reach latch");
  chk_latch_read: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R3
    (s_answer and (i_read && i_address == OFS_OUTPUT_LATCH))
    |-> (o_readdata == {16'h0000, output_latch}))
    else $error("latch read wrong");
  chk_level_read: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R5
    (s_answer and (i_read && i_address == OFS_PIN_LEVEL))
    |-> (o_readdata == {16'h0000, $past(pin_level)}))
    else $error("level read wrong");
  chk_unimpl_zero: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // R7
    ((pin_direction | output_latch | pin_level) & ~PIN_IMPL_MASK) == 16'h0000)
    else $error("missing pin reads nonzero");
  chk_dir_reset: assert property (@(posedge i_clk_sys) // R2
    !i_arst_n |=> (pin_direction == RST_PIN_DIRECTION || !i_arst_n))
    else $error("direction not input after reset");
  chk_unmapped_zero: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (s_answer and (i_read && i_address[1:0] != 2'h0)) |-> o_readdata == 32'h0000_0000)
    else $error("unmapped read nonzero");

endmodule // spio_port

// *** sim/spio_far_model.sv ***
// Model of the board pins facing the shared pin I/O port
`timescale 1ns/1ps
module spio_far_model
  import spio_pkg::*;
(
  input wire spio_pad_t i_pad,                   // Pad drive from the port
  input wire logic [PIN_W-1:0] i_ext_en,         // External driver active per pin
  input wire logic [PIN_W-1:0] i_ext_val,        // External driver level per pin
  output logic [PIN_W-1:0] o_pin_in              // Resolved wire level
);
  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // The port driver wins, then the external driver, else the board pull-up.
  // The bench never lets both drive one pin, so contention is not modelled.
  always_comb begin
    for (int i = 0; i < PIN_W; i++) begin
      if (i_pad.oe[i]) begin
        o_pin_in[i] = i_pad.out[i];
      end else if (i_ext_en[i]) begin
        o_pin_in[i] = i_ext_val[i];
      end else begin
        o_pin_in[i] = 1'b1;                      // Pull-up lifts a released pin
      end
    end
  end
endmodule // spio_far_model

// *** sim/tb_top.sv ***
// Self-checking testbench for the shared pin I/O port
`timescale 1ns/1ps
module tb_top;
  import spio_pkg::*;
  // ------------------------------------------------------------
  // Clock, reset and stimulus
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] av_addr = 4'h0;
  logic av_read = 1'b0;
  logic av_write = 1'b0;
  logic [DATA_W-1:0] av_wdata = 32'h0000_0000;
  logic [BE_W-1:0] av_be = 4'h0;
  logic [DATA_W-1:0] av_rdata;
  logic av_wait;
  spio_periph_t periph = '0;                     // Peripheral output path
  logic [PIN_W-1:0] periph_in;
  logic [PIN_W-1:0] pin_in;
  spio_pad_t pad;
  logic [PIN_W-1:0] ext_en = 16'h0000;           // Bench drives pins when set
  logic [PIN_W-1:0] ext_val = 16'h0000;
  logic [PIN_W-1:0] own;                         // Pins the peripheral owns
  logic [PIN_W-1:0] eout;                        // Expected pad output
  int n_errors = 0;
  int check_count = 0;

  always #5 clk_sys = ~clk_sys;

  spio_port dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_address(av_addr),
    .i_read(av_read), .i_write(av_write), .i_writedata(av_wdata), .i_byteenable(av_be),
    .o_readdata(av_rdata), .o_waitrequest(av_wait), .i_periph(periph),
    .o_periph_in(periph_in), .i_pin_in(pin_in), .o_pad(pad));
  spio_far_model far (.i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_pin_in(pin_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon transfer; waitrequest is sampled at each rising edge and the
  // transfer completes at the edge where it is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr,
                     input logic [DATA_W-1:0] data, input logic [BE_W-1:0] be,
                     output logic [DATA_W-1:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys);
    av_addr <= addr;
    av_read <= !wr;
    av_write <= wr;
    av_wdata <= data;
    av_be <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (av_wait !== 1'b0 && n < 100);
    if (av_wait !== 1'b0) n_errors++;
    rdata = av_rdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] addr, input logic [15:0] data,
                    input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] d;
    bus(1'b1, addr, {16'h0000, data}, be, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] d);
    bus(1'b0, addr, 32'h0000_0000, 4'hF, d);
  endtask

  // Let n edges pass, then sample in the settled half of the cycle
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic test_done;
    $display("Checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    logic [DATA_W-1:0] d;
    rd(OFS_PIN_DIRECTION, d);
    check("dir_rst", d, {16'h0000, PIN_IMPL_MASK});
    rd(OFS_OUTPUT_LATCH, d);
    check("lat_rst", d, 32'h0000_0000);
    rd(OFS_OPEN_DRAIN_SELECT, d);
    check("od_rst", d, 32'h0000_0000);
    check("oe_rst", {16'h0000, pad.oe}, 32'h0000_0000);
  endtask

  // Latch and direction, missing pins read zero
  task automatic test_latch_dir;
    logic [DATA_W-1:0] d;
    wr(OFS_OUTPUT_LATCH, 16'hFFFF, 4'hF);
    rd(OFS_OUTPUT_LATCH, d);
    check("lat_rd", d, {16'h0000, PIN_IMPL_MASK});
    wr(OFS_PIN_DIRECTION, 16'h0000, 4'hF);
    settle(2);
    check("oe_out", {16'h0000, pad.oe}, {16'h0000, PIN_IMPL_MASK});
    check("out_lat", {16'h0000, pad.out}, {16'h0000, PIN_IMPL_MASK});
    wr(OFS_PIN_DIRECTION, 16'hFFFF, 4'hF);
    rd(OFS_PIN_DIRECTION, d);
    check("dir_rd", d, {16'h0000, PIN_IMPL_MASK});
    settle(2);
    check("oe_in", {16'h0000, pad.oe}, 32'h0000_0000);
  endtask

  // Input levels through two synchroniser stages; level write hits latch
  task automatic test_level;
    logic [DATA_W-1:0] d;
    @(posedge clk_sys);
    ext_en <= 16'hFFFF;
    ext_val <= 16'hA5C3;
    settle(4);
    rd(OFS_PIN_LEVEL, d);
    check("lvl_rd", d, {16'h0000, 16'hA5C3 & PIN_IMPL_MASK});
    check("pin_feed", {16'h0000, periph_in}, {16'h0000, 16'hA5C3 & PIN_IMPL_MASK});
    @(posedge clk_sys);
    ext_val <= 16'h5A3C;
    settle(1);
    check("sync_1", {16'h0000, periph_in}, {16'h0000, 16'hA5C3 & PIN_IMPL_MASK});
    settle(1);
    check("sync_2", {16'h0000, periph_in}, {16'h0000, 16'h5A3C & PIN_IMPL_MASK});
    wr(OFS_PIN_LEVEL, 16'h1234, 4'h3);
    rd(OFS_OUTPUT_LATCH, d);
    check("lvl_wr", d, 32'h0000_1234);
    ext_en <= 16'h0000;
  endtask

  // Peripheral takes some pins, idle and input-only sharers leave the port
  task automatic test_periph;
    logic [DATA_W-1:0] d;
    wr(OFS_OUTPUT_LATCH, 16'h3C3C, 4'hF);
    wr(OFS_PIN_DIRECTION, 16'h0000, 4'hF);
    periph <= '{enable: 16'h3FFF, drive: 16'h3F0F, data: 16'h1234};
    own = 16'h3FFF & 16'h3F0F & PERIPH_OUT_MASK;
    eout = ((16'h1234 & own) | (16'h3C3C & ~own)) & PIN_IMPL_MASK;
    settle(4);
    check("per_out", {16'h0000, pad.out}, {16'h0000, eout});
    check("per_oe", {16'h0000, pad.oe}, {16'h0000, PIN_IMPL_MASK});
    rd(OFS_PIN_LEVEL, d);
    check("per_lvl", d, {16'h0000, eout});
    check("per_feed", {16'h0000, periph_in}, {16'h0000, eout & own});
    periph <= '0;
  endtask

  // Open drain pulls low on zero, releases on one; clearing restores push-pull
  task automatic test_open_drain;
    logic [DATA_W-1:0] d;
    wr(OFS_OUTPUT_LATCH, 16'h0000, 4'hF);
    wr(OFS_OUTPUT_LATCH, 16'hFFFF, 4'h1);
    rd(OFS_OUTPUT_LATCH, d);
    check("lane_wr", d, 32'h0000_00FF);
    wr(OFS_OPEN_DRAIN_SELECT, 16'hFFFF, 4'hF);
    settle(4);
    check("od_oe", {16'h0000, pad.oe}, 32'h0000_3F00);
    check("od_out", {16'h0000, pad.out}, 32'h0000_0000);
    rd(OFS_PIN_LEVEL, d);
    check("od_lvl", d, 32'h0000_00FF);
    wr(OFS_OPEN_DRAIN_SELECT, 16'h0000, 4'hF);
    settle(2);
    check("pp_oe", {16'h0000, pad.oe}, {16'h0000, PIN_IMPL_MASK});
    check("pp_out", {16'h0000, pad.out}, 32'h0000_00FF);
  endtask

  // Unmapped offset reads zero and a write there changes nothing
  task automatic test_unmapped;
    logic [DATA_W-1:0] d;
    wr(4'h2, 16'hFFFF, 4'hF);
    rd(4'h2, d);
    check("unm_rd", d, 32'h0000_0000);
    rd(OFS_OUTPUT_LATCH, d);
    check("unm_lat", d, 32'h0000_00FF);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_reset();
    test_latch_dir();
    test_level();
    test_periph();
    test_open_drain();
    test_unmapped();
    @(posedge clk_sys);
    arst_n <= 1'b0;                              // Second reset in mid-run
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_reset();
    test_done();
  end

  // The run needs well under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule // tb_top
